//--- shared/scs_pkg.sv
// scs_pkg: register map, field layout, reset values and delays for the
// system clock source switch. assumes a 10 mhz register clock.
package scs_pkg;
   localparam int unsigned CLK_HZ            = 10_000_000;

   // register byte addresses (one aligned word each)
   localparam logic [7:0] OSC_CTRL_ADDR      = 8'h00;
   localparam logic [7:0] OSC_STAT_ADDR      = 8'h04;
   localparam logic [7:0] T1_CTRL_ADDR       = 8'h08;

   // oscillator_control_reg fields
   localparam int unsigned SEL_LSB           = 0;
   localparam int unsigned IFS_LSB           = 3;
   localparam int unsigned IFS_W             = 4;
   // oscillator_status_reg fields
   localparam int unsigned EXT_ACT_BIT       = 0;
   localparam int unsigned SEC_RDY_BIT       = 1;
   localparam int unsigned SWITCHING_BIT     = 2;
   localparam int unsigned CUR_SRC_LSB       = 4;
   // timer1_control_reg fields
   localparam int unsigned SEC_EN_BIT        = 3;

   // reset values
   localparam logic [1:0] SEL_RST            = 2'h0;
   localparam logic [3:0] IFS_RST            = 4'h0;
   localparam logic       SEC_EN_RST         = 1'b0;

   // switch delays
   localparam int unsigned HF_DELAY_NS       = 2000;
   localparam int unsigned HF_DELAY_CYC      =
      (HF_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned EXT_DELAY_CYC     = 2;
   localparam int unsigned LF_DELAY_CYC      = 1;
   localparam int unsigned SEC_DELAY_CYC     = 1024;

   typedef enum logic [1:0] {
      SCS_SRC_CONFIG,
      SCS_SRC_SECONDARY,
      SCS_SRC_LF_INT,
      SCS_SRC_HF_INT
   } scs_src_e;
endpackage

//--- rtl/scs_edge_count.sv
// scs_edge_count: counts rising edges of a slow oscillator sample up to
// a limit and raises done. samples are synchronous to clk_i.
`timescale 1ns/100ps
module scs_edge_count #(
   parameter int unsigned LIMIT = 1024
) (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic clear_i,
   input  wire logic osc_i,
   output logic      done_o
);
   localparam int unsigned W = $clog2(LIMIT + 1);

   typedef struct packed {
      logic         prev;
      logic [W-1:0] cnt;
      logic         done;
   } scs_ec_s;

   scs_ec_s st;
   scs_ec_s next_st;

   // a zero limit would never raise done
   if (LIMIT < 1) begin : g_bad_limit
      $error("scs_edge_count: LIMIT must be at least 1");
   end

   always_comb begin
      next_st      = st;
      next_st.prev = osc_i;
      if (clear_i) begin
         next_st.cnt  = '0;
         next_st.done = 1'b0;
      end else if (osc_i && !st.prev && !st.done) begin
         next_st.cnt = st.cnt + W'(1);
         if (st.cnt == W'(LIMIT - 1)) begin
            next_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done_o = st.done;
endmodule

//--- rtl/scs_clk_mux.sv
// scs_clk_mux: picks one oscillator sample by source code.
// all sources are sampled levels synchronous to clk_i.
`timescale 1ns/100ps
module scs_clk_mux (
   input  wire logic             cfg_osc_i,
   input  wire logic             sec_osc_i,
   input  wire logic             lf_osc_i,
   input  wire logic             hf_osc_i,
   input  wire scs_pkg::scs_src_e sel_i,
   output logic                  clk_o
);
   always_comb begin
      case (sel_i)
         scs_pkg::SCS_SRC_CONFIG:    clk_o = cfg_osc_i;
         scs_pkg::SCS_SRC_SECONDARY: clk_o = sec_osc_i;
         scs_pkg::SCS_SRC_LF_INT:    clk_o = lf_osc_i;
         scs_pkg::SCS_SRC_HF_INT:    clk_o = hf_osc_i;
         default:                    clk_o = cfg_osc_i;
      endcase
   end
endmodule

//--- rtl/scs_clock_switch.sv
// scs_clock_switch: system clock source switch with apb registers.
// oscillators arrive as sampled levels synchronous to clk_i; the
// selected one is steered to the cpu and peripheral clock outputs.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module scs_clock_switch #(
   parameter int unsigned SEC_CYCLES = scs_pkg::SEC_DELAY_CYC,
   parameter int unsigned HF_CYCLES  = scs_pkg::HF_DELAY_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // configuration word oscillator field
   input  wire logic [1:0]  config_oscillator_field_i,
   // oscillator samples
   input  wire logic        config_osc_i,
   input  wire logic        secondary_osc_i,
   input  wire logic        low_freq_internal_osc_i,
   input  wire logic        high_freq_internal_osc_i,
   // outputs
   output logic             cpu_clk_o,
   output logic             periph_clk_o,
   output logic             secondary_osc_enable_o,
   output logic             switching_o
);
   localparam int unsigned DW = $clog2(
      (HF_CYCLES > scs_pkg::EXT_DELAY_CYC ? HF_CYCLES :
       scs_pkg::EXT_DELAY_CYC) + 2);

   // the delay counters cannot serve a zero wait
   if (SEC_CYCLES < 1) begin : g_bad_sec
      $error("scs_clock_switch: SEC_CYCLES must be at least 1");
   end
   if (HF_CYCLES < 1) begin : g_bad_hf
      $error("scs_clock_switch: HF_CYCLES must be at least 1");
   end

   typedef enum logic [1:0] {
      SW_IDLE,
      SW_WAIT_NEW,
      SW_WAIT_OLD
   } scs_sw_e;

   typedef struct packed {
      logic [1:0]        clock_source_select;
      logic [3:0]        internal_freq_select;
      logic              secondary_osc_enable;
      scs_pkg::scs_src_e cur;
      scs_pkg::scs_src_e tgt;
      scs_sw_e           sw;
      logic [DW-1:0]     dly;
      logic              new_prev;
      logic              old_prev;
      logic [31:0]       rdata;
   } scs_st_s;

   scs_st_s st;
   scs_st_s next_st;

   logic              sec_ready;
   logic              sys_clk;
   logic              new_clk;
   logic              old_clk;
   scs_pkg::scs_src_e want;

   // map select and frequency fields to a source
   function automatic scs_pkg::scs_src_e decode_src(
      input logic [1:0] sel,
      input logic [3:0] ifs
   );
      if (sel[1]) begin
         decode_src = (ifs == 4'h0) ? scs_pkg::SCS_SRC_LF_INT
                                    : scs_pkg::SCS_SRC_HF_INT;
      end else if (sel[0]) begin
         decode_src = scs_pkg::SCS_SRC_SECONDARY;
      end else begin
         decode_src = scs_pkg::SCS_SRC_CONFIG;
      end
   endfunction

   // only the three register words answer; others raise pslverr
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == scs_pkg::OSC_CTRL_ADDR) ||
                  (addr == scs_pkg::OSC_STAT_ADDR) ||
                  (addr == scs_pkg::T1_CTRL_ADDR);
   endfunction

   // status word: flags and the source now driving the clocks
   function automatic logic [31:0] status_word(
      input scs_pkg::scs_src_e cur,
      input logic              rdy,
      input logic              busy
   );
      status_word                            = 32'h0000_0000;
      status_word[scs_pkg::EXT_ACT_BIT]      =
         (cur == scs_pkg::SCS_SRC_CONFIG);
      status_word[scs_pkg::SEC_RDY_BIT]      = rdy;
      status_word[scs_pkg::SWITCHING_BIT]    = busy;
      status_word[scs_pkg::CUR_SRC_LSB +: 2] = cur;
   endfunction

   // secondary oscillator ready after SEC_CYCLES of its own edges (1024 by default)
   scs_edge_count #(
      .LIMIT (SEC_CYCLES)
   ) u_sec_ready (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (!st.secondary_osc_enable),
      .osc_i     (secondary_osc_i),
      .done_o    (sec_ready)
   );

   scs_clk_mux u_sys_mux (
      .cfg_osc_i (config_osc_i),
      .sec_osc_i (secondary_osc_i),
      .lf_osc_i  (low_freq_internal_osc_i),
      .hf_osc_i  (high_freq_internal_osc_i),
      .sel_i     (st.cur),
      .clk_o     (sys_clk)
   );

   scs_clk_mux u_new_mux (
      .cfg_osc_i (config_osc_i),
      .sec_osc_i (secondary_osc_i),
      .lf_osc_i  (low_freq_internal_osc_i),
      .hf_osc_i  (high_freq_internal_osc_i),
      .sel_i     (st.tgt),
      .clk_o     (new_clk)
   );

   assign old_clk = sys_clk;
   assign want    = decode_src(st.clock_source_select,
                               st.internal_freq_select);

   wire logic apb_wr = psel_i && penable_i && pwrite_i;
   wire logic apb_rd = psel_i && !penable_i && !pwrite_i;
   wire logic hit    = is_mapped(paddr_i);

   always_comb begin
      next_st          = st;
      next_st.new_prev = new_clk;
      next_st.old_prev = old_clk;

      // register writes take effect in the access phase
      if (apb_wr) begin
         case (paddr_i)
            scs_pkg::OSC_CTRL_ADDR: begin
               next_st.clock_source_select =
                  pwdata_i[scs_pkg::SEL_LSB +: 2];
               next_st.internal_freq_select =
                  pwdata_i[scs_pkg::IFS_LSB +: scs_pkg::IFS_W];
            end
            scs_pkg::T1_CTRL_ADDR: begin
               next_st.secondary_osc_enable =
                  pwdata_i[scs_pkg::SEC_EN_BIT];
            end
            default: begin
            end
         endcase
      end

      // read data captured in setup, presented during access
      if (apb_rd) begin
         next_st.rdata = 32'h0000_0000;
         case (paddr_i)
            scs_pkg::OSC_CTRL_ADDR: begin
               next_st.rdata[scs_pkg::SEL_LSB +: 2] =
                  st.clock_source_select;
               next_st.rdata[scs_pkg::IFS_LSB +: scs_pkg::IFS_W] =
                  st.internal_freq_select;
            end
            scs_pkg::OSC_STAT_ADDR: begin
               next_st.rdata = status_word(st.cur, sec_ready,
                                           st.sw != SW_IDLE);
            end
            scs_pkg::T1_CTRL_ADDR: begin
               next_st.rdata[scs_pkg::SEC_EN_BIT] =
                  st.secondary_osc_enable;
            end
            default: begin
            end
         endcase
      end

      // switch sequencer: cur keeps driving until the handover;
      // a target that never settles leaves the old source in charge
      case (st.sw)
         SW_IDLE: begin
            if (want != st.cur) begin
               next_st.tgt = want;
               next_st.dly = '0;
               next_st.sw  = SW_WAIT_NEW;
            end
         end
         SW_WAIT_NEW: begin
            if (want != st.tgt) begin
               // retarget restarts the wait
               next_st.tgt = want;
               next_st.dly = '0;
            end else begin
               case (st.tgt)
                  scs_pkg::SCS_SRC_SECONDARY: begin
                     // ready counter holds the SEC_CYCLES-edge wait
                     if (sec_ready) begin
                        next_st.cur = st.tgt;
                        next_st.sw  = SW_IDLE;
                     end
                  end
                  scs_pkg::SCS_SRC_LF_INT: begin
                     // one edge of the new clock, then one of the old
                     if (new_clk && !st.new_prev) begin
                        next_st.sw = SW_WAIT_OLD;
                     end
                  end
                  scs_pkg::SCS_SRC_HF_INT: begin
                     next_st.dly = st.dly + DW'(1);
                     if (st.dly == DW'(HF_CYCLES - 1)) begin
                        next_st.cur = st.tgt;
                        next_st.sw  = SW_IDLE;
                     end
                  end
                  default: begin
                     // configuration source: external mode wait
                     next_st.dly = st.dly + DW'(1);
                     if (st.dly ==
                         DW'(scs_pkg::EXT_DELAY_CYC - 1)) begin
                        next_st.cur = st.tgt;
                        next_st.sw  = SW_IDLE;
                     end
                  end
               endcase
            end
         end
         SW_WAIT_OLD: begin
            if (old_clk && !st.old_prev) begin
               next_st.cur = st.tgt;
               next_st.sw  = SW_IDLE;
            end
         end
         default: begin
            next_st.sw = SW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st                      <= '0;
         st.clock_source_select  <= scs_pkg::SEL_RST;
         st.internal_freq_select <= scs_pkg::IFS_RST;
         st.secondary_osc_enable <= scs_pkg::SEC_EN_RST;
         st.cur                  <= scs_pkg::SCS_SRC_CONFIG;
         st.tgt                  <= scs_pkg::SCS_SRC_CONFIG;
         st.sw                   <= SW_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // unused config field: the configured source arrives already picked
   wire logic [1:0] unused_cfg = config_oscillator_field_i;

   assign cpu_clk_o              = sys_clk;
   assign periph_clk_o           = sys_clk;
   assign secondary_osc_enable_o = st.secondary_osc_enable;
   assign switching_o            = (st.sw != SW_IDLE);
   assign prdata_o               = st.rdata;
   assign pready_o               = 1'b1;
   assign pslverr_o              = psel_i && penable_i && !hit;
endmodule

//--- testbench/scs_clock_switch_properties.sv
// port-level checks for the system clock source switch.
// assumes oscillator samples change only at clk_i rising edges.
`timescale 1ns/100ps
module scs_clock_switch_properties #(
   parameter int unsigned SEC_CYCLES = scs_pkg::SEC_DELAY_CYC,
   parameter int unsigned HF_CYCLES  = scs_pkg::HF_DELAY_CYC
) (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [1:0]  config_oscillator_field_i,
   input wire logic        config_osc_i,
   input wire logic        secondary_osc_i,
   input wire logic        low_freq_internal_osc_i,
   input wire logic        high_freq_internal_osc_i,
   input wire logic        cpu_clk_o,
   input wire logic        periph_clk_o,
   input wire logic        secondary_osc_enable_o,
   input wire logic        switching_o
);
   localparam int HF_LO = HF_CYCLES;
   localparam int HF_HI = HF_CYCLES + 8;
   logic acc;
   logic wr_ctrl;
   logic wr_t1;
   assign acc = psel_i && penable_i && pwrite_i && pready_o;
   assign wr_ctrl = acc && paddr_i == scs_pkg::OSC_CTRL_ADDR;
   assign wr_t1 = acc && paddr_i == scs_pkg::T1_CTRL_ADDR;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_clk_pair: assert property (cpu_clk_o == periph_clk_o)
      else $error("cpu and peripheral clocks differ");
   a_reset_src: assert property ($rose(reset_n_i) |->
      (cpu_clk_o == config_osc_i)[*2])
      else $error("clock not from config source after reset");
   a_ext_switch: assert property (wr_ctrl && pwdata_i[1:0] == 2'h0
      |-> ##[2:8] (cpu_clk_o == config_osc_i && !switching_o))
      else $error("config source switch late");
   a_hf_switch: assert property (wr_ctrl && pwdata_i[1]
      && pwdata_i[6:3] != 4'h0 |-> ##[HF_LO:HF_HI]
      (cpu_clk_o == high_freq_internal_osc_i && !switching_o))
      else $error("high frequency switch late");
   a_lf_switch: assert property (wr_ctrl && pwdata_i[1]
      && pwdata_i[6:3] == 4'h0 |-> ##[2:12]
      (cpu_clk_o == low_freq_internal_osc_i && !switching_o))
      else $error("low frequency switch late");
   a_sec_switch: assert property (wr_ctrl && pwdata_i[1:0] == 2'h1
      && secondary_osc_enable_o |-> ##[2:8]
      (cpu_clk_o == secondary_osc_i && !switching_o))
      else $error("secondary switch late");
   a_sec_enable: assert property (wr_t1 |=>
      secondary_osc_enable_o == $past(pwdata_i[3]))
      else $error("secondary enable not updated");
   a_sec_wait: assert property (wr_ctrl && pwdata_i[1:0] == 2'h1
      && !secondary_osc_enable_o |-> ##2 switching_o[*4])
      else $error("switch to stopped secondary not held");
   c_wr_ctrl: cover property (wr_ctrl);
   c_sw_done: cover property ($fell(switching_o));
   c_err: cover property (psel_i && penable_i && pslverr_o);
endmodule
bind scs_clock_switch scs_clock_switch_properties #(
   .SEC_CYCLES(SEC_CYCLES), .HF_CYCLES(HF_CYCLES)
) scs_clock_switch_properties_i (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .config_oscillator_field_i(config_oscillator_field_i),
   .config_osc_i(config_osc_i), .secondary_osc_i(secondary_osc_i),
   .low_freq_internal_osc_i(low_freq_internal_osc_i),
   .high_freq_internal_osc_i(high_freq_internal_osc_i),
   .cpu_clk_o(cpu_clk_o), .periph_clk_o(periph_clk_o),
   .secondary_osc_enable_o(secondary_osc_enable_o),
   .switching_o(switching_o)
);

//--- testbench/scs_clock_switch_tb_top.sv
// self-checking bench for the clock source switch over apb.
// assumes zero-wait apb slave and shortened switch delays.
`timescale 1ns/100ps
module scs_clock_switch_tb_top;
   localparam logic [7:0] CT = scs_pkg::OSC_CTRL_ADDR;
   localparam logic [7:0] SR = scs_pkg::OSC_STAT_ADDR;
   localparam logic [7:0] T1 = scs_pkg::T1_CTRL_ADDR;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic        e;
   } scs_exp_s;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [1:0]  cfg_field = 2'h0;
   logic        cfg_osc = 1'b0;
   logic        sec_osc = 1'b0;
   logic        lf_osc = 1'b0;
   logic        hf_osc = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sec_en;
   logic        switching;
   logic [1:0]  lf_div = 2'h0;
   logic [3:0]  ifs;
   logic [1:0]  cur;
   logic [7:0]  a;
   logic [31:0] v;
   scs_exp_s    got;
   scs_exp_s    exp_q[$];
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [1:0]  t_sel[6] = '{2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h0};
   logic        t_nz[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

   scs_clock_switch #(.SEC_CYCLES(4), .HF_CYCLES(2)) scs_clock_switch_i (
      .clk_i(clk), .reset_n_i(reset_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .config_oscillator_field_i(cfg_field),
      .config_osc_i(cfg_osc), .secondary_osc_i(sec_osc),
      .low_freq_internal_osc_i(lf_osc),
      .high_freq_internal_osc_i(hf_osc), .cpu_clk_o(),
      .periph_clk_o(), .secondary_osc_enable_o(sec_en),
      .switching_o(switching));

   always #50 clk = ~clk;

   // secondary only runs while enabled, so its ready count can stall;
   // cfg, lf and hf each have their own pattern; sec toggles every cycle like hf
   always @(posedge clk) begin
      lf_div  <= lf_div + 2'h1;
      cfg_osc <= lf_div[0] ^ lf_div[1];
      hf_osc  <= ~hf_osc;
      lf_osc  <= lf_div[1];
      if (sec_en === 1'b1) sec_osc <= ~sec_osc;
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         got = exp_q.pop_front();
         cmp_count++;
         if (pslverr !== got.e || (!pwrite && (prdata & got.m) !== got.d))
            begin
            n_fail++;
            $display("unexpected at %0t: addr %h data %h", $time, paddr,
               prdata);
         end
      end
   end

   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, input scs_exp_s x);
      exp_q.push_back(x);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
      apb(1'b0, ad, 32'h0, '{d & m, m, e});
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                     input logic e);
      apb(1'b1, ad, d, '{32'h0, 32'h0, e});
   endtask

   task automatic wait_sw();
      repeat (3) @(negedge clk);
      while (switching !== 1'b0) @(negedge clk);
   endtask

   function automatic logic [31:0] st(input logic [1:0] c,
                                      input logic r, input logic s);
      return {26'h0, c, 1'b0, s, r, c == 2'h0};
   endfunction

   initial begin
      void'($urandom(45374));
      repeat (8) @(posedge clk);
      reset_n   <= 1'b1;
      cfg_field <= 2'($urandom);
      rd(CT, 32'h0, 32'h7b, 1'b0);
      rd(T1, 32'h0, 32'h8, 1'b0);
      rd(SR, st(2'h0, 1'b0, 1'b0), 32'h37, 1'b0);
      a = {6'($urandom_range(63, 3)), 2'h0};
      wr(a, $urandom, 1'b1);
      rd(a, 32'h0, 32'hffffffff, 1'b1);
      for (int i = 0; i < 6; i++) begin
         ifs = t_nz[i] ? 4'($urandom_range(15, 1)) : 4'h0;
         if (!t_sel[i][1]) ifs = 4'($urandom);
         cur = !t_sel[i][1] ? {1'b0, t_sel[i][0]} : {1'b1, t_nz[i]};
         v = $urandom;
         v[6:0] = {ifs, 1'b0, t_sel[i]};
         wr(CT, v, 1'b0);
         wait_sw();
         rd(CT, v, 32'h7b, 1'b0);
         rd(SR, st(cur, 1'b0, 1'b0), 32'h37, 1'b0);
      end
      // secondary picked while stopped: old source must keep running
      wr(CT, 32'h1, 1'b0);
      repeat (10) @(posedge clk);
      rd(SR, st(2'h0, 1'b0, 1'b1), 32'h37, 1'b0);
      wr(T1, 32'h8, 1'b0);
      rd(SR, st(2'h0, 1'b0, 1'b1), 32'h37, 1'b0);
      rd(T1, 32'h8, 32'h8, 1'b0);
      wait_sw();
      rd(SR, st(2'h1, 1'b1, 1'b0), 32'h37, 1'b0);
      wr(CT, 32'h0, 1'b0);
      wait_sw();
      rd(SR, st(2'h0, 1'b1, 1'b0), 32'h37, 1'b0);
      wr(CT, 32'h1, 1'b0);
      wait_sw();
      rd(SR, st(2'h1, 1'b1, 1'b0), 32'h37, 1'b0);
      wr(T1, 32'h0, 1'b0);
      rd(SR, 32'h0, 32'h2, 1'b0);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(CT, 32'h0, 32'h7b, 1'b0);
      rd(SR, st(2'h0, 1'b0, 1'b0), 32'h37, 1'b0);
      // let the checker take the last answer before the verdict
      repeat (2) @(posedge clk);
      if (exp_q.size() != 0) begin
         n_fail++;
         $display("unexpected at %0t: %0d answers never seen", $time,
            exp_q.size());
      end
      stop_test();
   end
endmodule
